// File: rtl/csac_ctrl.sv
// Functional notes
// - Hold manual size per step, max 9999
// - Each step capacitive or inductive, any order
// - Recognition enabled sets step type automatically
// - Regulated steps follow regulation demand
// - Forced-on stays on, drops on critical or when blocked by shedding
// - Forced-off stays off, no regulation
// - Three consecutive failures mark step faulty
// - Faulty excluded 24 h or until restart
// - Per-step cycle counter, readable, clearable, bounded
// - Manual reset latches until Esc 3 s
// - Auto reset clears with condition
// - Log five latest alarms, drop oldest
// - Distortion over limit for delay trips alarm
// - Optionally shed steps sequentially, block 30 min
// - Distortion threshold programmable, default 7 %
// - Twelve independent steps, regulated default
// - Trigger delay in seconds, default 60
module csac_ctrl #(
  parameter int SEC_CYCLES   = csac_pkg::SEC_CYCLES,
  parameter int ESC_HOLD_S   = csac_pkg::ESC_HOLD_S,
  parameter int FAULT_HOLD_S = csac_pkg::FAULT_HOLD_S,
  parameter int BLOCK_HOLD_S = csac_pkg::BLOCK_HOLD_S
) (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     cfg_we_i,
  input  wire csac_pkg::csac_step_cfg_t cfg_i,
  input  wire logic                     cnt_clr_i,
  input  wire logic [3:0]               cnt_idx_i,
  input  wire logic                     recog_en_i,
  input  wire logic                     recog_done_i,
  input  wire logic [3:0]               recog_idx_i,
  input  wire csac_pkg::csac_type_t     recog_type_i,
  input  wire logic                     lockout_en_i,
  input  wire logic [11:0]              reg_demand_i,
  input  wire logic                     critical_i,
  input  wire logic                     sw_result_i,
  input  wire logic                     sw_fail_i,
  input  wire logic [3:0]               sw_idx_i,
  input  wire logic                     manual_reset_en_i,
  input  wire logic                     esc_key_i,
  input  wire logic                     shed_en_i,
  input  wire logic [7:0]               thd_limit_i,
  input  wire logic [7:0]               trip_delay_i,
  input  wire logic [7:0]               voltage_distortion_level_i,
  input  wire logic [3:0]               rd_idx_i,
  output logic [11:0]                   step_on_o,
  output logic [11:0]                   step_faulty_o,
  output logic [13:0]                   rd_size_o,
  output logic                          rd_inductive_o,
  output csac_pkg::csac_type_t          rd_type_o,
  output logic [17:0]                   rd_cycles_o,
  output logic                          alarm_relay_o,
  output logic                          distortion_alarm_o,
  output csac_pkg::csac_log_t [4:0]     alarm_log_o
);
  localparam int N = csac_pkg::NUM_STEPS;
  localparam int ESC_CYC = ESC_HOLD_S * SEC_CYCLES;

  // Persistent settings live in this array (non-volatile in system)
  csac_pkg::csac_type_t          stype [N];
  logic [csac_pkg::SIZE_W-1:0]   ssize [N];
  logic                          sind  [N];
  logic [csac_pkg::CNT_W-1:0]    scnt  [N];
  logic [1:0]                    fails [N];
  logic [csac_pkg::LONG_W-1:0]   lock_s [N];
  logic [csac_pkg::SEC_W-1:0]    sec_cnt;
  logic                          sec_tick;
  logic [31:0]                   esc_cnt;
  logic                          esc_reset;
  logic                          thd_over;
  logic [7:0]                    trip_s;
  logic                          trip_cond;
  logic [7:0]                    shed_s;
  logic [11:0]                   blocked;
  logic [csac_pkg::LONG_W-1:0]   block_s;
  logic [11:0]                   next_on;
  logic [11:0]                   faulty_vec;

  assign thd_over = voltage_distortion_level_i > thd_limit_i;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= sec_cnt == csac_pkg::SEC_W'(SEC_CYCLES - 1);
      if (sec_cnt == csac_pkg::SEC_W'(SEC_CYCLES - 1))
        sec_cnt <= '0;
      else
        sec_cnt <= sec_cnt + 1'b1;
    end
  end

  // Step configuration, recognition and fault marking
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < N; i++) begin
        stype[i]  <= csac_pkg::CSAC_REG;
        ssize[i]  <= '0;
        sind[i]   <= 1'b0;
        fails[i]  <= '0;
        lock_s[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++)
        if (sec_tick && lock_s[i] != '0)
          lock_s[i] <= lock_s[i] - 1'b1;
      if (cfg_we_i && cfg_i.idx < 4'(N)) begin
        if (!recog_en_i)
          ssize[cfg_i.idx] <= (cfg_i.size > csac_pkg::SIZE_MAX) ?
                              csac_pkg::SIZE_MAX : cfg_i.size;
        sind[cfg_i.idx]   <= cfg_i.inductive;
        stype[cfg_i.idx]  <= cfg_i.stype;
        fails[cfg_i.idx]  <= '0;
        lock_s[cfg_i.idx] <= '0;
      end
      if (recog_en_i && recog_done_i && recog_idx_i < 4'(N))
        stype[recog_idx_i] <= recog_type_i;
      if (sw_result_i && sw_idx_i < 4'(N)) begin
        if (!sw_fail_i)
          fails[sw_idx_i] <= '0;
        else if (lockout_en_i &&
                 fails[sw_idx_i] >= csac_pkg::FAIL_LIMIT - 2'h1) begin
          stype[sw_idx_i]  <= csac_pkg::CSAC_FLTY;
          lock_s[sw_idx_i] <= csac_pkg::LONG_W'(FAULT_HOLD_S);
          fails[sw_idx_i]  <= '0;
        end else if (fails[sw_idx_i] != csac_pkg::FAIL_LIMIT)
          fails[sw_idx_i] <= fails[sw_idx_i] + 2'h1;
      end
    end
  end

  // Faulty type only excludes while lock timer runs
  always_comb
    for (int i = 0; i < N; i++)
      faulty_vec[i] = stype[i] == csac_pkg::CSAC_FLTY &&
                      lock_s[i] != '0;

  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (stype[i])
        csac_pkg::CSAC_REG:  next_on[i] = reg_demand_i[i];
        csac_pkg::CSAC_FON:  next_on[i] = !critical_i;
        csac_pkg::CSAC_FOFF: next_on[i] = 1'b0;
        csac_pkg::CSAC_FLTY: next_on[i] = !faulty_vec[i] && reg_demand_i[i];
        default:             next_on[i] = 1'b0;
      endcase
      if (blocked[i])
        next_on[i] = 1'b0;
    end
  end

  // Switching cycle counters, one per step
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < N; i++)
        scnt[i] <= '0;
    end else begin
      for (int i = 0; i < N; i++)
        if (next_on[i] && !step_on_o[i] &&
            scnt[i] != csac_pkg::CNT_MAX)
          scnt[i] <= scnt[i] + 1'b1;
      if (cnt_clr_i && cnt_idx_i < 4'(N))
        scnt[cnt_idx_i] <= '0;
    end
  end

  // Distortion trip delay
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trip_s    <= '0;
      trip_cond <= 1'b0;
    end else if (!thd_over) begin
      trip_s    <= '0;
      trip_cond <= 1'b0;
    end else if (sec_tick && !trip_cond) begin
      if (trip_s + 8'h01 >= trip_delay_i)
        trip_cond <= 1'b1;
      trip_s <= trip_s + 8'h01;
    end
  end

  // Sequential shedding and 30 minute block
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      blocked <= '0;
      shed_s  <= '0;
      block_s <= '0;
    end else if (trip_cond && shed_en_i) begin
      block_s <= csac_pkg::LONG_W'(BLOCK_HOLD_S);
      if (sec_tick) begin
        if (shed_s + 8'h01 >= trip_delay_i) begin
          shed_s <= '0;
          for (int i = N - 1; i >= 0; i--)
            if (step_on_o[i] && !blocked[i]) begin
              blocked <= blocked | (12'h001 << i);
              break;
            end
        end else
          shed_s <= shed_s + 8'h01;
      end
    end else if (blocked != '0) begin
      shed_s <= '0;
      if (sec_tick) begin
        if (block_s <= csac_pkg::LONG_W'(1)) begin
          blocked <= '0;
          block_s <= '0;
        end else
          block_s <= block_s - 1'b1;
      end
    end
  end

  // Esc hold detection
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      esc_cnt   <= '0;
      esc_reset <= 1'b0;
    end else begin
      esc_reset <= esc_key_i && esc_cnt == 32'(ESC_CYC - 1);
      if (!esc_key_i)
        esc_cnt <= '0;
      else if (esc_cnt < 32'(ESC_CYC))
        esc_cnt <= esc_cnt + 1'b1;
    end
  end

  // Alarm latch, relay and log
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      distortion_alarm_o <= 1'b0;
      alarm_relay_o      <= 1'b0;
      alarm_log_o        <= '0;
    end else begin
      if (trip_cond) begin
        distortion_alarm_o <= 1'b1;
        alarm_relay_o      <= 1'b1;
        if (!distortion_alarm_o)
          alarm_log_o <= {alarm_log_o[3:0],
                          csac_pkg::csac_log_t'({1'b1, 4'h1})};
      end else if (!manual_reset_en_i || esc_reset) begin
        distortion_alarm_o <= 1'b0;
        alarm_relay_o      <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      step_on_o      <= '0;
      step_faulty_o  <= '0;
      rd_size_o      <= '0;
      rd_inductive_o <= 1'b0;
      rd_type_o      <= csac_pkg::CSAC_REG;
      rd_cycles_o    <= '0;
    end else begin
      step_on_o     <= next_on;
      step_faulty_o <= faulty_vec;
      if (rd_idx_i < 4'(N)) begin
        rd_size_o      <= ssize[rd_idx_i];
        rd_inductive_o <= sind[rd_idx_i];
        rd_type_o      <= stype[rd_idx_i];
        rd_cycles_o    <= scnt[rd_idx_i];
      end
    end
  end

  property p_forced_off;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      stype[0] == csac_pkg::CSAC_FOFF |=> !step_on_o[0];
  endproperty
  a_forced_off: assert property (p_forced_off)
    else $error("forced-off step energised");
  property p_forced_on;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      stype[1] == csac_pkg::CSAC_FON && !critical_i && !blocked[1]
      |=> step_on_o[1];
  endproperty
  a_forced_on: assert property (p_forced_on)
    else $error("forced-on step not energised");
  property p_regulated;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      stype[2] == csac_pkg::CSAC_REG && !blocked[2]
      |=> step_on_o[2] == $past(reg_demand_i[2]);
  endproperty
  a_regulated: assert property (p_regulated)
    else $error("regulated step ignores demand");
  sequence s_third_fail;
    sw_result_i && sw_fail_i && lockout_en_i && !cfg_we_i &&
    sw_idx_i == 4'h3 && fails[3] == 2'h2;
  endsequence
  property p_fault_mark;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      s_third_fail |=> stype[3] == csac_pkg::CSAC_FLTY ##1 step_faulty_o[3];
  endproperty
  a_fault_mark: assert property (p_fault_mark)
    else $error("step not marked faulty after three failures");

  property p_cnt_bound;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      rd_cycles_o <= csac_pkg::CNT_MAX;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("cycle counter above bound");

  property p_auto_clear;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      !manual_reset_en_i && !thd_over ##1 !manual_reset_en_i
      |=> !alarm_relay_o;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("alarm did not clear automatically");

  property p_manual_hold;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      manual_reset_en_i && alarm_relay_o && !esc_reset |=> alarm_relay_o;
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("manual alarm dropped without escape hold");

  property p_trip;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      trip_cond |=> distortion_alarm_o && alarm_relay_o;
  endproperty
  a_trip: assert property (p_trip)
    else $error("distortion alarm not raised");

  property p_log;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      trip_cond && !distortion_alarm_o
      |=> alarm_log_o[0].valid && alarm_log_o[1] == $past(alarm_log_o[0]);
  endproperty
  a_log: assert property (p_log)
    else $error("alarm log not shifted");
endmodule : csac_ctrl

// File: rtl/csac_pkg.sv
package csac_pkg;
  localparam int          NUM_STEPS     = 12;
  localparam int          SIZE_W        = 14;
  localparam logic [13:0] SIZE_MAX      = 14'h270f;  // 9999
  localparam int          CNT_W         = 18;
  localparam logic [17:0] CNT_MAX       = 18'h3ff70; // 262000
  localparam logic [1:0]  FAIL_LIMIT    = 2'h3;
  localparam int          LOG_DEPTH     = 5;
  localparam logic [7:0]  THD_DEFAULT   = 8'h07;     // 7 %
  localparam logic [7:0]  DELAY_DEFAULT = 8'h3c;     // 60 s
  localparam int          CLK_HZ        = 250_000_000;
  localparam int          SEC_CYCLES    = CLK_HZ;
  localparam int          ESC_HOLD_S    = 3;
  localparam int          FAULT_HOLD_S  = 24 * 3600;
  localparam int          BLOCK_HOLD_S  = 30 * 60;
  localparam int          SEC_W         = 28;
  localparam int          LONG_W        = 17;

  typedef enum logic [1:0] {
    CSAC_REG, CSAC_FON, CSAC_FOFF, CSAC_FLTY
  } csac_type_t;

  typedef struct packed {
    logic [3:0]        idx;
    logic              inductive;
    logic [SIZE_W-1:0] size;
    csac_type_t        stype;
  } csac_step_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } csac_log_t;
endpackage : csac_pkg

// File: dv/csac_contactor_model.sv
module csac_contactor_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [11:0] step_on_i,
  input  wire logic [11:0] fail_mask_i,
  output logic             sw_result_o,
  output logic             sw_fail_o,
  output logic [3:0]       sw_idx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] prev;
  logic [11:0] pend;
  initial begin
    prev = '0;
    pend = '0;
    sw_result_o = 1'b0;
    sw_fail_o = 1'b0;
    sw_idx_o = 4'h0;
  end
  // One outcome per cycle for each contactor closing
  always @(negedge ref_clk_i) begin
    logic       hit;
    logic       fail;
    logic [3:0] idx;
    hit  = 1'b0;
    fail = ~sw_fail_o;
    idx  = ~sw_idx_o;
    pend = rstn_i ? (pend | (step_on_i & ~prev)) : '0;
    prev = step_on_i;
    for (int i = 0; i < 12; i++) begin
      if (pend[i] && !hit) begin
        hit     = 1'b1;
        fail    = fail_mask_i[i];
        idx     = i[3:0];
        pend[i] = 1'b0;
      end
    end
    sw_result_o = hit;
    sw_fail_o   = fail;
    sw_idx_o    = idx;
  end
endmodule : csac_contactor_model

// File: dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  logic ref_clk_i = 0, rstn_i = 0, cfg_we = 0, cnt_clr = 0, recog_en = 0;
  logic recog_done = 0, lock_en = 0, crit = 0, man_en = 0, esc = 0;
  logic shed_en = 0, sw_res, sw_fail;
  logic [3:0] cnt_idx = 0, recog_idx = 0, rd_idx = 0, sw_idx;
  logic [11:0] demand = 0, fmask = 0, step_on, faulty;
  logic [7:0] thd = csac_pkg::THD_DEFAULT, dly = csac_pkg::DELAY_DEFAULT;
  logic [7:0] vdl = 0;
  logic [13:0] rd_size;
  logic rd_ind, relay, alarm;
  logic [17:0] rd_cyc;
  csac_pkg::csac_step_cfg_t cfg = '0;
  csac_pkg::csac_type_t recog_type = csac_pkg::CSAC_REG, rd_type;
  csac_pkg::csac_log_t [4:0] alog;
  csac_pkg::csac_type_t tt [12];
  logic [13:0] sz [12];
  int bad_count = 0, samples_checked = 0;

  csac_ctrl #(.SEC_CYCLES(SC), .ESC_HOLD_S(3), .FAULT_HOLD_S(5),
    .BLOCK_HOLD_S(3)) dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cfg_we_i(cfg_we), .cfg_i(cfg),
    .cnt_clr_i(cnt_clr), .cnt_idx_i(cnt_idx), .recog_en_i(recog_en),
    .recog_done_i(recog_done), .recog_idx_i(recog_idx),
    .recog_type_i(recog_type), .lockout_en_i(lock_en),
    .reg_demand_i(demand), .critical_i(crit), .sw_result_i(sw_res),
    .sw_fail_i(sw_fail), .sw_idx_i(sw_idx), .manual_reset_en_i(man_en),
    .esc_key_i(esc), .shed_en_i(shed_en), .thd_limit_i(thd),
    .trip_delay_i(dly), .voltage_distortion_level_i(vdl),
    .rd_idx_i(rd_idx), .step_on_o(step_on), .step_faulty_o(faulty),
    .rd_size_o(rd_size), .rd_inductive_o(rd_ind), .rd_type_o(rd_type),
    .rd_cycles_o(rd_cyc), .alarm_relay_o(relay),
    .distortion_alarm_o(alarm), .alarm_log_o(alog));
  csac_contactor_model model (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .step_on_i(step_on),
    .fail_mask_i(fmask), .sw_result_o(sw_res), .sw_fail_o(sw_fail),
    .sw_idx_o(sw_idx));

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [13:0] exp_size(input logic [13:0] v);
    return (v > csac_pkg::SIZE_MAX) ? csac_pkg::SIZE_MAX : v;
  endfunction : exp_size
  function automatic logic [11:0] exp_on(input logic [11:0] d,
                                         input logic c);
    logic [11:0] r;
    for (int i = 0; i < 12; i++) begin
      r[i] = (tt[i] == csac_pkg::CSAC_REG) ? d[i] :
             (tt[i] == csac_pkg::CSAC_FON) ? !c : 1'b0;
    end
    return r;
  endfunction : exp_on

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  task automatic wcfg(input int i, input logic ind, input logic [13:0] s,
                      input csac_pkg::csac_type_t t);
    cfg = '{idx: i[3:0], inductive: ind, size: s, stype: t};
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    cyc(1);
  endtask : wcfg
  task automatic rd(input int i);
    rd_idx = i[3:0];
    cyc(2);
  endtask : rd
  task automatic wait_alarm(input logic v, input int n);
    int k;
    k = 0;
    while (alarm !== v && k < n) begin
      cyc(1);
      k++;
    end
    chk(alarm, v);
    chk(relay, v);
  endtask : wait_alarm
  task automatic pulse_step(input int i);
    demand[i] = 1;
    cyc(4);
    demand[i] = 0;
    cyc(4);
  endtask : pulse_step
  task automatic print_verdict;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    int k;
    logic ind;
    void'($urandom(58119));
    cyc(2);
    rstn_i = 1;
    rd(5);
    chk(rd_type, csac_pkg::CSAC_REG);
    chk({step_on, alarm, relay}, 0);
    for (int i = 0; i < 12; i++) begin
      tt[i] = csac_pkg::CSAC_REG;
      sz[i] = 0;
    end
    for (int n = 0; n < 16; n++) begin
      k = (n < 12) ? n : $urandom % 12;
      sz[k] = (n == 0) ? 14'h270f : (n == 1) ? 14'h2710 : 14'($urandom);
      tt[k] = csac_pkg::csac_type_t'($urandom % 3);
      ind = 1'($urandom);
      wcfg(k, ind, sz[k], tt[k]);
      rd(k);
      chk(rd_size, exp_size(sz[k]));
      chk(rd_ind, ind);
      chk(rd_type, tt[k]);
      sz[k] = exp_size(sz[k]);
    end
    for (int n = 0; n < 10; n++) begin
      demand = 12'($urandom);
      crit = (n > 6);
      cyc(3);
      chk(step_on, exp_on(demand, crit));
    end
    demand = 0;
    crit = 0;
    recog_en = 1;
    wcfg(0, 0, 14'h0123, csac_pkg::CSAC_REG);
    recog_idx = 0;
    recog_type = csac_pkg::CSAC_FOFF;
    recog_done = 1;
    cyc(1);
    recog_done = 0;
    rd(0);
    chk(rd_type, csac_pkg::CSAC_FOFF);
    chk(rd_size, sz[0]);
    recog_en = 0;
    for (int i = 0; i < 12; i++) wcfg(i, 0, 14'h0010, csac_pkg::CSAC_REG);
    cnt_idx = 4'h2;
    cnt_clr = 1;
    cyc(1);
    cnt_clr = 0;
    k = 1 + $urandom % 5;
    repeat (k) pulse_step(2);
    rd(2);
    chk(rd_cyc, k);
    cnt_clr = 1;
    cyc(1);
    cnt_clr = 0;
    rd(2);
    chk(rd_cyc, 0);
    fmask = 12'h008;
    lock_en = 1;
    repeat (3) pulse_step(3);
    demand[3] = 1;
    rd(3);
    chk(faulty[3], 1);
    chk(rd_type, csac_pkg::CSAC_FLTY);
    chk(step_on[3], 0);
    demand[3] = 0;
    cyc(5 * SC + 8);
    chk(faulty[3], 0);
    fmask = 0;
    wcfg(3, 0, 14'h0010, csac_pkg::CSAC_REG);
    demand[3] = 1;
    rd(3);
    chk(rd_type, csac_pkg::CSAC_REG);
    chk(step_on[3], 1);
    demand = 0;
    fmask = 12'h010;
    repeat (3) pulse_step(4);
    chk(faulty[4], 1);
    rstn_i = 1'b0;
    cyc(2);
    rstn_i = 1'b1;
    rd(4);
    chk({faulty[4], step_on[4]}, 0);
    chk(rd_type, csac_pkg::CSAC_REG);
    fmask = 12'h000;
    vdl = thd;
    cyc(300);
    chk(alarm, 0);
    vdl = thd + 8'h01;
    cyc(230);
    chk(alarm, 0);
    wait_alarm(1, 30);
    chk(alog[0], {1'b1, 4'h1});
    vdl = 0;
    wait_alarm(0, 4);
    dly = 8'h02;
    man_en = 1;
    vdl = 8'h40;
    wait_alarm(1, 3 * SC + 8);
    chk(alog[1], {1'b1, 4'h1});
    vdl = 0;
    cyc(20);
    chk(alarm, 1);
    esc = 1;
    wait_alarm(0, 3 * SC + 8);
    esc = 0;
    man_en = 0;
    shed_en = 1;
    demand = 12'h003;
    cyc(3);
    vdl = 8'h40;
    wait_alarm(1, 3 * SC + 8);
    cyc(2 * 2 * SC + 3 * SC);
    chk(step_on, 0);
    vdl = 0;
    wait_alarm(0, 4);
    cyc(2);
    chk(step_on, 0);
    cyc(3 * SC + 8);
    chk(step_on, 12'h003);
    print_verdict();
  end
endmodule : tb_top
